// ---- logic/sas_pkg.sv ----
// Constants, register map and state codes of the SAR converter sequencer
package sas_pkg;

  // ----------------------------------------------------------------
  // Register addresses (CPU space)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RESULT_LO  = 16'hff08;
  localparam logic [15:0] ADDR_RESULT_HI  = 16'hff09;
  localparam logic [15:0] ADDR_RESULT_NRW = 16'hff0a;
  localparam logic [15:0] ADDR_PIN_CFG    = 16'hff22;
  localparam logic [15:0] ADDR_MODE       = 16'hff28;
  localparam logic [15:0] ADDR_PIN9_DIR   = 16'hff29;
  localparam logic [15:0] ADDR_CHAN_SEL   = 16'hff2b;
  localparam logic [15:0] ADDR_PIN07_DIR  = 16'hff48;

  // ----------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_MODE        = 8'h00;
  localparam logic [7:0]  RST_CHAN_SEL    = 8'h00;
  localparam logic [7:0]  RST_PIN_CFG     = 8'h00;
  localparam logic [7:0]  RST_PIN_DIR     = 8'hff;
  localparam logic [7:0]  PIN9_FIXED_ONES = 8'hfe;
  localparam logic [15:0] RST_RESULT_WIDE = 16'h0000;
  localparam logic [7:0]  RST_RESULT_NRW  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_LV_LSB     = 1;
  localparam int MODE_FR_LSB     = 3;
  localparam int MODE_START_BIT  = 7;
  localparam int CHAN_FIELD_W    = 4;
  localparam int PIN_CFG_W       = 4;
  localparam int CODE_W          = 10;
  localparam int RESULT_SHIFT    = 6;
  localparam int NUM_PINS        = 9;
  localparam logic [3:0] PIN_CFG_MAX = 4'h9;

  // ----------------------------------------------------------------
  // Timing: sampling cycles by level bits, per-bit cycles by freq bits
  // ----------------------------------------------------------------
  localparam logic [7:0] SAMPLE_CYC [4] = '{8'h0c, 8'h10, 8'h18, 8'h20};
  localparam logic [7:0] STEP_CYC   [8] = '{8'h02, 8'h03, 8'h04, 8'h06,
                                            8'h08, 8'h0c, 8'h10, 8'h18};

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SAMPLE  = 4'b0010,
    ST_COMPARE = 4'b0100,
    ST_STORE   = 4'b1000
  } sas_state_t;

endpackage

// ---- logic/sas_tick.sv ----
// Reloadable down-counter giving one-cycle step enables
module sas_tick (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       restart,
  input  wire logic [7:0] period,
  // Enable pulse
  output logic            tick
);

  logic [7:0] count;

  // Reload on restart or expiry so every phase gets its full length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (restart || count == 8'h00) begin
      count <= period - 8'h01;
    end else begin
      count <= count - 8'h01;
    end
  end

  // Pulse on expiry only; gating it with restart would loop through the state decode
  assign tick = (count == 8'h00);

endmodule

// ---- logic/sas_buf2.sv ----
// Two-entry valid/ready buffer between the approximation and result registers
module sas_buf2 #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   fill;
  logic         push;
  logic         pop;

  assign in_ready  = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage and pointers; a stalled drain fills it and stops the source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'd0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + 2'd1;
      end else if (pop && !push) begin
        fill <= fill - 2'd1;
      end
    end
  end

endmodule

// ---- logic/sas_top.sv ----
// SAR converter sequencer: registers, approximation engine and pin decode
module sas_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // CPU register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic [7:0]  REG_WMASK,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA,
  // Analog comparator and tap selector
  input  wire logic        COMP_GE,
  output logic             COMP_ENABLE,
  output logic             SH_SAMPLE,
  output logic [9:0]       TAP_CODE,
  output logic [8:0]       CHAN_ONEHOT,
  // Pin function decode
  output logic [8:0]       PIN_OUT_EN,
  output logic [8:0]       PIN_ANALOG,
  output logic [8:0]       PIN_CONVERT,
  // Conversion end
  output logic             CONV_DONE_IRQ
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  converter_mode_reg;
  logic [3:0]  channel_select_reg;
  logic [3:0]  pin_function_config;
  logic [7:0]  analog_pins0_7_direction;
  logic        pin9_dir_bit;
  logic [15:0] result_wide;
  logic [7:0]  result_narrow;

  logic        wr_mode;
  logic        wr_chan;
  logic        wr_cfg;
  logic        wr_pin9;
  logic        wr_pin07;
  logic        cfg_write;
  logic        result_read;
  logic [7:0]  pin9_full;

  // Masked write: a single-bit write carries one mask bit, a byte write all
  function automatic logic [7:0] merge(input logic [7:0] old_v);
    merge = (old_v & ~REG_WMASK) | (REG_WDATA & REG_WMASK);
  endfunction

  // Address decode
  always_comb begin
    wr_mode  = 1'b0;
    wr_chan  = 1'b0;
    wr_cfg   = 1'b0;
    wr_pin9  = 1'b0;
    wr_pin07 = 1'b0;
    if (REG_WR && REG_ADDR == sas_pkg::ADDR_MODE) begin
      wr_mode = 1'b1;
    end else if (REG_WR && REG_ADDR == sas_pkg::ADDR_CHAN_SEL) begin
      wr_chan = 1'b1;
    end else if (REG_WR && REG_ADDR == sas_pkg::ADDR_PIN_CFG) begin
      wr_cfg = 1'b1;
    end else if (REG_WR && REG_ADDR == sas_pkg::ADDR_PIN9_DIR) begin
      wr_pin9 = 1'b1;
    end else if (REG_WR && REG_ADDR == sas_pkg::ADDR_PIN07_DIR) begin
      wr_pin07 = 1'b1;
    end
  end

  assign cfg_write   = wr_mode || wr_chan || wr_cfg || wr_pin9 || wr_pin07;
  assign result_read = REG_RD && (REG_ADDR == sas_pkg::ADDR_RESULT_LO ||
                                  REG_ADDR == sas_pkg::ADDR_RESULT_HI ||
                                  REG_ADDR == sas_pkg::ADDR_RESULT_NRW);
  assign pin9_full   = sas_pkg::PIN9_FIXED_ONES | {7'h00, pin9_dir_bit};

  // Software-written registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      converter_mode_reg       <= sas_pkg::RST_MODE;
      channel_select_reg       <= sas_pkg::RST_CHAN_SEL[3:0];
      pin_function_config      <= sas_pkg::RST_PIN_CFG[3:0];
      analog_pins0_7_direction <= sas_pkg::RST_PIN_DIR;
      pin9_dir_bit             <= sas_pkg::RST_PIN_DIR[0];
    end else begin
      if (wr_mode) begin
        converter_mode_reg <= merge(converter_mode_reg);
      end
      if (wr_chan) begin
        channel_select_reg <= 4'(merge({4'h0, channel_select_reg}));
      end
      if (wr_cfg) begin
        pin_function_config <= 4'(merge({4'h0, pin_function_config}));
      end
      if (wr_pin07) begin
        analog_pins0_7_direction <= merge(analog_pins0_7_direction);
      end
      if (wr_pin9) begin
        pin9_dir_bit <= 1'(merge(pin9_full));
      end
    end
  end

  // Read port; upper pin9 bits are tied ones
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == sas_pkg::ADDR_RESULT_LO) begin
        REG_RDATA <= result_wide[7:0];
      end else if (REG_ADDR == sas_pkg::ADDR_RESULT_HI) begin
        REG_RDATA <= result_wide[15:8];
      end else if (REG_ADDR == sas_pkg::ADDR_RESULT_NRW) begin
        REG_RDATA <= result_narrow;
      end else if (REG_ADDR == sas_pkg::ADDR_MODE) begin
        REG_RDATA <= converter_mode_reg;
      end else if (REG_ADDR == sas_pkg::ADDR_CHAN_SEL) begin
        REG_RDATA <= {4'h0, channel_select_reg};
      end else if (REG_ADDR == sas_pkg::ADDR_PIN_CFG) begin
        REG_RDATA <= {4'h0, pin_function_config};
      end else if (REG_ADDR == sas_pkg::ADDR_PIN9_DIR) begin
        REG_RDATA <= pin9_full;
      end else if (REG_ADDR == sas_pkg::ADDR_PIN07_DIR) begin
        REG_RDATA <= analog_pins0_7_direction;
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Approximation engine
  // ----------------------------------------------------------------
  sas_pkg::sas_state_t state;
  sas_pkg::sas_state_t next_state;
  logic [9:0]  sar;
  logic [3:0]  bit_idx;
  logic        start_on;
  logic        step_tick;
  logic        timer_restart;
  logic [7:0]  timer_period;
  logic [1:0]  lv_sel;
  logic [2:0]  fr_sel;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [9:0]  buf_out_data;

  assign start_on = converter_mode_reg[sas_pkg::MODE_START_BIT];
  assign lv_sel   = converter_mode_reg[sas_pkg::MODE_LV_LSB +: 2];
  assign fr_sel   = converter_mode_reg[sas_pkg::MODE_FR_LSB +: 3];

  // Next state; losing start or a channel write overrides the sequence
  always_comb begin
    next_state = state;
    if (!start_on) begin
      next_state = sas_pkg::ST_IDLE;
    end else if (wr_chan) begin
      next_state = sas_pkg::ST_SAMPLE;
    end else begin
      case (state)
        sas_pkg::ST_IDLE: begin
          next_state = sas_pkg::ST_SAMPLE;
        end
        sas_pkg::ST_SAMPLE: begin
          if (step_tick) begin
            next_state = sas_pkg::ST_COMPARE;
          end
        end
        sas_pkg::ST_COMPARE: begin
          if (step_tick && bit_idx == 4'd0) begin
            next_state = sas_pkg::ST_STORE;
          end
        end
        sas_pkg::ST_STORE: begin
          // Waits only while the buffer is full
          if (buf_in_ready || cfg_write) begin
            next_state = sas_pkg::ST_SAMPLE;
          end
        end
        default: begin
          next_state = sas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Phase timer reloads on every phase change or abort
  assign timer_restart = (next_state != state) || wr_chan;
  assign timer_period  = (next_state == sas_pkg::ST_SAMPLE) ?
                         sas_pkg::SAMPLE_CYC[lv_sel] :
                         sas_pkg::STEP_CYC[fr_sel];

  sas_tick u_tick (
    .clk     (MCLK),
    .rst_n   (RESETN),
    .restart (timer_restart),
    .period  (timer_period),
    .tick    (step_tick)
  );

  // State register
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= sas_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Trial and compare, one bit per step, most significant first
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sar     <= 10'h000;
      bit_idx <= 4'd0;
    end else if (next_state == sas_pkg::ST_SAMPLE) begin
      sar     <= 10'h200;
      bit_idx <= 4'd9;
    end else if (state == sas_pkg::ST_COMPARE && step_tick) begin
      sar[bit_idx] <= COMP_GE;
      if (bit_idx != 4'd0) begin
        sar[bit_idx - 4'd1] <= 1'b1;
        bit_idx             <= bit_idx - 4'd1;
      end
    end
  end

  // A coinciding configuration write drops the finished code
  assign buf_in_valid  = (state == sas_pkg::ST_STORE) && start_on && !cfg_write;
  // A result read in this cycle delays the register update
  assign buf_out_ready = !result_read;

  sas_buf2 #(
    .W (sas_pkg::CODE_W)
  ) u_buf (
    .clk       (MCLK),
    .rst_n     (RESETN),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (sar),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // Result registers and end-of-conversion pulse
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      result_wide   <= sas_pkg::RST_RESULT_WIDE;
      result_narrow <= sas_pkg::RST_RESULT_NRW;
      CONV_DONE_IRQ <= 1'b0;
    end else begin
      CONV_DONE_IRQ <= 1'b0;
      if (buf_out_valid && buf_out_ready) begin
        result_wide   <= {buf_out_data, 6'h00};
        result_narrow <= buf_out_data[9:2];
        CONV_DONE_IRQ <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog side and pin decode, all registered
  // ----------------------------------------------------------------
  logic [8:0] dir_in;
  logic [8:0] is_analog;
  logic [8:0] chan_dec;
  logic [3:0] cfg_sat;

  assign dir_in  = {pin9_dir_bit, analog_pins0_7_direction};
  assign cfg_sat = (pin_function_config > sas_pkg::PIN_CFG_MAX) ?
                   sas_pkg::PIN_CFG_MAX : pin_function_config;

  // Pins below the configured count are digital; codes above 8 select none
  always_comb begin
    for (int i = 0; i < sas_pkg::NUM_PINS; i++) begin
      is_analog[i] = (4'(i) >= cfg_sat);
      chan_dec[i]  = (channel_select_reg == 4'(i));
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      COMP_ENABLE <= 1'b0;
      SH_SAMPLE   <= 1'b0;
      TAP_CODE    <= 10'h000;
      CHAN_ONEHOT <= 9'h000;
      PIN_OUT_EN  <= 9'h000;
      PIN_ANALOG  <= 9'h000;
      PIN_CONVERT <= 9'h000;
    end else begin
      COMP_ENABLE <= converter_mode_reg[sas_pkg::MODE_ENABLE_BIT];
      SH_SAMPLE   <= (state == sas_pkg::ST_SAMPLE);
      TAP_CODE    <= sar;
      CHAN_ONEHOT <= chan_dec;
      PIN_OUT_EN  <= ~dir_in & ~is_analog;
      PIN_ANALOG  <= dir_in & is_analog;
      PIN_CONVERT <= dir_in & is_analog & chan_dec &
                     {9{state != sas_pkg::ST_IDLE}};
    end
  end

endmodule

// ---- verif/sas_asserts.sv ----
// Concurrent checks on the SAR sequencer top-level ports
module sas_asserts (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RESETN,
  // Register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_WMASK,
  input wire logic        REG_WR,
  // Converter side
  input wire logic        COMP_ENABLE,
  input wire logic        SH_SAMPLE,
  input wire logic [9:0]  TAP_CODE,
  input wire logic [8:0]  CHAN_ONEHOT,
  input wire logic [8:0]  PIN_OUT_EN,
  input wire logic [8:0]  PIN_ANALOG,
  input wire logic        CONV_DONE_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mode_wr;
  logic chan_wr;
  logic start_q;
  // Write decode for the two control registers
  assign mode_wr = REG_WR && REG_ADDR == sas_pkg::ADDR_MODE;
  assign chan_wr = REG_WR && REG_ADDR == sas_pkg::ADDR_CHAN_SEL;
  // Shadow of the start bit, so channel writes can be judged
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) start_q <= 1'b0;
    else if (mode_wr && REG_WMASK[7]) start_q <= REG_WDATA[7];
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence s_lone_mode;
    mode_wr && REG_WMASK[0] ##1 !mode_wr;
  endsequence
  sequence s_lone_chan;
    chan_wr && REG_WMASK == 8'hff && REG_WDATA < 8'h09 ##1 !chan_wr;
  endsequence
  sequence s_first_trial;
    $fell(SH_SAMPLE) ##[0:2] TAP_CODE == 10'h200 ##1 !SH_SAMPLE && TAP_CODE != 10'h200;
  endsequence
  a_irq_pulse: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("done pulse longer than one cycle");
  a_comp_follow: assert property (s_lone_mode |-> ##1 COMP_ENABLE == $past(REG_WDATA[0], 2))
    else $error("comparator enable does not follow mode bit 0");
  a_chan_map: assert property (s_lone_chan |-> ##1 CHAN_ONEHOT == 9'h001 << $past(REG_WDATA[3:0], 2))
    else $error("channel decode wrong");
  a_pin_excl: assert property ((PIN_OUT_EN & PIN_ANALOG) == 9'h000)
    else $error("pin both analog and driven");
  a_tap_first: assert property ($fell(SH_SAMPLE) |-> ##[0:2] TAP_CODE == 10'h200)
    else $error("first trial not at half scale");
  a_tap_second: assert property (s_first_trial |-> TAP_CODE inside {10'h300, 10'h100})
    else $error("second trial not at a quarter point");
  a_stop_quiet: assert property (mode_wr && REG_WMASK[7] && !REG_WDATA[7] |-> ##2 !CONV_DONE_IRQ [*8])
    else $error("done pulse after stop");
  a_chan_restart: assert property (chan_wr && start_q |-> ##[1:2] SH_SAMPLE)
    else $error("channel write did not restart sampling");
endmodule

// ---- verif/sas_comp_model.sv ----
// Comparator with sample-and-hold facing the sequencer
module sas_comp_model (
  // Clock
  input  wire logic       clk,
  // Sequencer side
  input  wire logic       enable,
  input  wire logic       sample,
  input  wire logic [9:0] tap,
  // Analog source as a fraction of full scale
  input  wire logic [9:0] vin,
  output logic            ge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held;
  logic       wobble = 1'b0;
  // Track while sampling, freeze on hold
  always_ff @(posedge clk) begin
    if (sample) held <= vin;
    wobble <= ~wobble;
  end
  // A disabled comparator gives garbage, never a steady answer
  assign ge = enable ? (held >= tap) : wobble;
endmodule

// ---- verif/sas_top_tb.sv ----
// Self-checking bench for the SAR converter sequencer
module sas_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [15:0] REG_ADDR = 16'h0000;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [7:0]  REG_WMASK = 8'h00;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [7:0]  REG_RDATA;
  logic        COMP_GE, COMP_ENABLE, SH_SAMPLE, CONV_DONE_IRQ;
  logic [9:0]  TAP_CODE;
  logic [9:0]  vin = 10'h000;
  logic [8:0]  CHAN_ONEHOT, PIN_OUT_EN, PIN_ANALOG, PIN_CONVERT;
  int          error_cnt = 0;
  int          cmp_count = 0;
  localparam logic [9:0] VTAB [9] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155,
                                      10'h2aa, 10'h001, 10'h3fe, 10'h0c3};
  // 10 MHz clock
  always #50 MCLK = ~MCLK;
  sas_top u_sas_top (.MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WMASK(REG_WMASK), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .COMP_GE(COMP_GE), .COMP_ENABLE(COMP_ENABLE),
    .SH_SAMPLE(SH_SAMPLE), .TAP_CODE(TAP_CODE), .CHAN_ONEHOT(CHAN_ONEHOT),
    .PIN_OUT_EN(PIN_OUT_EN), .PIN_ANALOG(PIN_ANALOG), .PIN_CONVERT(PIN_CONVERT),
    .CONV_DONE_IRQ(CONV_DONE_IRQ));
  sas_comp_model u_sas_comp_model (.clk(MCLK), .enable(COMP_ENABLE), .sample(SH_SAMPLE),
    .tap(TAP_CODE), .vin(vin), .ge(COMP_GE));
  // ------
  // Shared tasks
  // ------
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write strobe for one edge, then one more cycle so registered outputs settle
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge MCLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WMASK = m;
    REG_WR = 1'b1;
    @(negedge MCLK);
    REG_WR = 1'b0;
    @(negedge MCLK);
  endtask
  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] e);
    @(negedge MCLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge MCLK);
    REG_RD = 1'b0;
    @(negedge MCLK);
    chk(what, 16'(e), 16'(REG_RDATA));
  endtask
  task automatic chk_code(input logic [9:0] c);
    rdchk("result low", sas_pkg::ADDR_RESULT_LO, {c[1:0], 6'h00});
    rdchk("result high", sas_pkg::ADDR_RESULT_HI, c[9:2]);
    rdchk("result narrow", sas_pkg::ADDR_RESULT_NRW, c[9:2]);
  endtask
  // Bounded wait for the done pulse; returns cycles waited
  task automatic wait_irq(output int n);
    n = 0;
    while (CONV_DONE_IRQ !== 1'b1 && n < 1000) begin
      @(negedge MCLK);
      n++;
    end
    if (n >= 1000) chk("done pulse", 16'h0001, 16'h0000);
    @(negedge MCLK);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    rdchk("pin9 dir", sas_pkg::ADDR_PIN9_DIR, 8'hff);
    chk_code(10'h000);
    rdchk("unmapped", 16'hff00, 8'h00);
    chk("analog pins", 16'h01ff, 16'(PIN_ANALOG));
    chk("out enables", 16'h0000, 16'(PIN_OUT_EN));
  endtask
  task automatic t_pin;
    wr(sas_pkg::ADDR_PIN9_DIR, 8'h00, 8'h01);
    rdchk("pin9 bit write", sas_pkg::ADDR_PIN9_DIR, 8'hfe);
    wr(sas_pkg::ADDR_PIN_CFG, 8'h09, 8'hff);
    chk("pin9 output", 16'h0100, 16'(PIN_OUT_EN));
    wr(sas_pkg::ADDR_PIN07_DIR, 8'h00, 8'hff);
    chk("all outputs", 16'h01ff, 16'(PIN_OUT_EN));
    wr(sas_pkg::ADDR_PIN9_DIR, 8'hff, 8'hff);
    wr(sas_pkg::ADDR_PIN07_DIR, 8'hff, 8'hff);
    wr(sas_pkg::ADDR_PIN_CFG, 8'h04, 8'hff);
    chk("cfg4 analog", 16'h01f0, 16'(PIN_ANALOG));
    chk("cfg4 outputs", 16'h0000, 16'(PIN_OUT_EN));
    wr(sas_pkg::ADDR_PIN_CFG, 8'h00, 8'hff);
  endtask
  // Enable first and wait over 1 us; each channel still skips its first result and checks the second
  task automatic t_conv;
    int n;
    wr(sas_pkg::ADDR_MODE, 8'h01, 8'hff);
    repeat (12) @(negedge MCLK);
    wr(sas_pkg::ADDR_MODE, 8'h81, 8'hff);
    for (int c = 0; c < 9; c++) begin
      vin = VTAB[c];
      wr(sas_pkg::ADDR_CHAN_SEL, 8'(c), 8'hff);
      chk("channel", 16'(1 << c), 16'(CHAN_ONEHOT));
      chk("converting pin", 16'(1 << c), 16'(PIN_CONVERT));
      wait_irq(n);
      wait_irq(n);
      chk_code(VTAB[c]);
    end
  endtask
  // Every frequency and level code, timed from a channel write
  task automatic t_time;
    int n;
    int e;
    for (int k = 0; k < 8; k++) begin
      wr(sas_pkg::ADDR_MODE, {2'b10, 3'(k), 2'(k % 4), 1'b1}, 8'hff);
      wr(sas_pkg::ADDR_CHAN_SEL, 8'h02, 8'hff);
      wait_irq(n);
      e = sas_pkg::SAMPLE_CYC[k % 4] + 10 * sas_pkg::STEP_CYC[k];
      cmp_count++;
      if (n < e - 1 || n > e + 4) begin
        error_cnt++;
        $display("[ERR] conv time expected %0d seen %0d", e, n);
      end
    end
  endtask
  // Stop in mid-compare, then resume with enable still set
  task automatic t_stop;
    int n;
    wr(sas_pkg::ADDR_MODE, 8'h81, 8'hff);
    vin = 10'h3ff;
    wr(sas_pkg::ADDR_CHAN_SEL, 8'h02, 8'hff);
    repeat (20) @(negedge MCLK);
    wr(sas_pkg::ADDR_MODE, 8'h00, 8'h80);
    repeat (200) begin
      @(negedge MCLK);
      if (CONV_DONE_IRQ !== 1'b0) chk("pulse after stop", 16'h0000, 16'h0001);
    end
    rdchk("kept result", sas_pkg::ADDR_RESULT_NRW, VTAB[8][9:2]);
    wr(sas_pkg::ADDR_MODE, 8'h80, 8'h80);
    wait_irq(n);
    rdchk("resumed result", sas_pkg::ADDR_RESULT_NRW, 8'hff);
  endtask
  // Mode writes every cycle collide with every completion
  task automatic t_collide;
    int n;
    vin = 10'h155;
    @(negedge MCLK);
    REG_ADDR = sas_pkg::ADDR_MODE;
    REG_WDATA = 8'h81;
    REG_WMASK = 8'hff;
    REG_WR = 1'b1;
    repeat (150) begin
      @(negedge MCLK);
      if (CONV_DONE_IRQ !== 1'b0) chk("pulse under writes", 16'h0000, 16'h0001);
    end
    REG_WDATA = 8'h00;
    REG_WMASK = 8'h80;
    @(negedge MCLK);
    REG_WR = 1'b0;
    rdchk("result under writes", sas_pkg::ADDR_RESULT_NRW, 8'hff);
    wr(sas_pkg::ADDR_MODE, 8'h80, 8'h80);
    wait_irq(n);
    rdchk("result after writes", sas_pkg::ADDR_RESULT_NRW, 8'h55);
  endtask
  // Reads held across a completion see the old result; the update follows them
  task automatic t_rdhold;
    int n;
    vin = 10'h2aa;
    wait_irq(n);
    wait_irq(n);
    vin = 10'h3ff;
    REG_ADDR = sas_pkg::ADDR_RESULT_NRW;
    REG_RD = 1'b1;
    repeat (40) begin
      @(negedge MCLK);
      if (CONV_DONE_IRQ !== 1'b0) chk("pulse during reads", 16'h0000, 16'h0001);
    end
    chk("read before update", 16'h00aa, 16'(REG_RDATA));
    REG_RD = 1'b0;
    wait_irq(n);
    chk("update after reads", 16'h0001, 16'(n <= 1));
    rdchk("result after reads", sas_pkg::ADDR_RESULT_NRW, 8'hff);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge MCLK);
    RESETN = 1'b1;
    t_reset();
    t_pin();
    t_conv();
    t_time();
    t_stop();
    t_collide();
    t_rdhold();
    test_done();
  end
  // Watchdog: the run needs a few thousand cycles, this allows 20000
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end
endmodule

bind sas_top sas_asserts u_sas_asserts (.MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WMASK(REG_WMASK), .REG_WR(REG_WR),
  .COMP_ENABLE(COMP_ENABLE), .SH_SAMPLE(SH_SAMPLE), .TAP_CODE(TAP_CODE),
  .CHAN_ONEHOT(CHAN_ONEHOT), .PIN_OUT_EN(PIN_OUT_EN), .PIN_ANALOG(PIN_ANALOG),
  .CONV_DONE_IRQ(CONV_DONE_IRQ));
